// >>> rtl/arith_option_cycle_sequencer.sv
// sequencer linking the arithmetic option to the processor timing chain
// assumes timing pulses t1..t3, fetch level and write-back strobe come from same-clock logic
`timescale 1ns/1ps
module arith_option_cycle_sequencer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic t1_i,
  input wire logic t2_i,
  input wire logic t3_i,
  input wire logic fetch_cycle_i,
  input wire logic [arith_option_pkg::WORD_W-1:0] instr_i,
  input wire logic write_back_done_i,
  input wire logic norm_done_i,
  output logic start_arithmetic_pulse_o,
  output logic instruction_register_load_o,
  output logic [arith_option_pkg::OPCODE_W-1:0] deposit_zero_opcode_o,
  output logic halt_timing_level_o,
  output logic resume_timing_pulse_o,
  output logic addsub_step_o,
  output logic shift_step_o,
  output logic busy_o,
  output logic [arith_option_pkg::FUNC_W-1:0] func_o
);
  import arith_option_pkg::*;

  typedef struct packed {
    seq_state_t state;
    logic [FUNC_W-1:0] func;
    logic start;
    logic load_instr;
    logic [OPCODE_W-1:0] opcode;
    logic halt;
    logic resume;
    logic addsub;
    logic shift;
    logic busy;
    logic [1:0] seen; // hybrid t1 and t2 already seen
  } seq_reg_t;

  seq_reg_t r;
  seq_reg_t next_r;
  logic [OPCODE_W-1:0] instr_opcode;
  logic [FUNC_W-1:0] instr_func;
  logic [COUNT_W-1:0] instr_count;
  logic option_fetch;
  logic needs_arg;
  logic step_load;
  logic step_advance;
  logic [COUNT_W-1:0] step_count;
  logic step_last;
  logic step_overflow;

  // ************************************************************
  // instruction decode
  // ************************************************************
  assign instr_opcode = instr_i[OPCODE_LSB +: OPCODE_W];
  assign instr_func = instr_i[FUNC_LSB +: FUNC_W];
  assign instr_count = instr_i[COUNT_LSB +: COUNT_W];
  // option word seen at T3 of a fetch cycle while idle
  assign option_fetch = (r.state == ST_IDLE) && fetch_cycle_i && t3_i &&
                        (instr_opcode == OPTION_OPCODE);
  assign needs_arg = (instr_func == FUNC_MUL) || (instr_func == FUNC_DIV);
  // step count loaded as its negative so n steps reach overflow
  assign step_load = option_fetch && (instr_func != FUNC_SETUP);
  assign step_advance = next_r.shift;

  step_counter #(
    .W(COUNT_W)
  ) u_step_counter (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .load_i(step_load),
    .value_i(COUNT_W'(~instr_count + 6'h01)),
    .step_i(step_advance),
    .count_o(step_count),
    .last_o(step_last),
    .overflow_o(step_overflow)
  );

  // ************************************************************
  // sequence control
  // ************************************************************
  // pulses default low each cycle; halt and busy are held levels
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.load_instr = 1'b0;
    next_r.opcode = '0;
    next_r.resume = 1'b0;
    next_r.addsub = 1'b0;
    next_r.shift = 1'b0;
    unique case (r.state)
      ST_IDLE: begin
        next_r.halt = 1'b0;
        if (option_fetch) begin
          next_r.func = instr_func;
          next_r.seen = 2'h0;
          next_r.busy = 1'b1;
          if (needs_arg) begin
            next_r.state = ST_HYBRID;
          end else begin
            next_r.halt = 1'b1;
            next_r.state = ST_ENTRY;
          end
        end
      end
      ST_HYBRID: begin
        // processor does T1/T2 work itself and reads the next word;
        // t3 counts only once this cycle's t1 and t2 have been seen
        if (t1_i && !fetch_cycle_i) begin
          next_r.seen[0] = 1'b1;
        end
        if (t2_i && !fetch_cycle_i && r.seen[0]) begin
          next_r.seen[1] = 1'b1;
        end
        if (t3_i && !fetch_cycle_i && r.seen[1]) begin
          next_r.start = 1'b1;
          next_r.load_instr = 1'b1;
          next_r.opcode = DEPOSIT_ZERO_OPCODE;
          next_r.state = ST_WBACK;
        end
      end
      ST_WBACK: begin
        if (write_back_done_i) begin
          next_r.halt = 1'b1;
          next_r.state = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        // branch point of the start/end sequence
        unique case (r.func)
          FUNC_MUL, FUNC_DIV: next_r.state = ST_MD_ADD;
          FUNC_NORM, FUNC_LONG_RIGHT, FUNC_LONG_LEFT, FUNC_ACC_LEFT: begin
            next_r.state = ST_SHIFT;
          end
          default: next_r.state = ST_END;
        endcase
      end
      ST_MD_ADD: begin
        next_r.addsub = 1'b1;
        next_r.state = ST_MD_SHIFT;
      end
      ST_MD_SHIFT: begin
        next_r.shift = 1'b1;
        next_r.state = step_last ? ST_END : ST_MD_ADD;
      end
      ST_SHIFT: begin
        if ((r.func == FUNC_NORM) && norm_done_i) begin
          next_r.state = ST_END;
        end else begin
          next_r.shift = 1'b1;
          if (step_last) begin
            next_r.state = ST_END;
          end
        end
      end
      ST_END: begin
        next_r.resume = 1'b1;
        next_r.busy = 1'b0;
        next_r.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r.state <= ST_IDLE;
      r.func <= FUNC_RESET;
      r.start <= 1'b0;
      r.load_instr <= 1'b0;
      r.opcode <= '0;
      r.halt <= 1'b0;
      r.resume <= 1'b0;
      r.addsub <= 1'b0;
      r.shift <= 1'b0;
      r.busy <= 1'b0;
      r.seen <= 2'h0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign start_arithmetic_pulse_o = r.start;
  assign instruction_register_load_o = r.load_instr;
  assign deposit_zero_opcode_o = r.opcode;
  assign halt_timing_level_o = r.halt;
  assign resume_timing_pulse_o = r.resume;
  assign addsub_step_o = r.addsub;
  assign shift_step_o = r.shift;
  assign busy_o = r.busy;
  assign func_o = r.func;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !clk_en_i);

  a_nomem_halt: assert property (option_fetch && !needs_arg |=>
    halt_timing_level_o && !start_arithmetic_pulse_o) else $error("no halt after fetch");
  a_nomem_one_fetch: assert property (option_fetch && !needs_arg |=>
    r.state == ST_ENTRY) else $error("non-memory op left fetch path");
  a_start_at_t3: assert property (r.state == ST_HYBRID && t3_i && !fetch_cycle_i |=>
    start_arithmetic_pulse_o ##1 !start_arithmetic_pulse_o) else $error("start pulse wrong");
  a_dzm_forced: assert property (start_arithmetic_pulse_o |->
    instruction_register_load_o && deposit_zero_opcode_o == 4'hc) else $error("opcode not forced");
  a_halt_after_wb: assert property (r.state == ST_WBACK && write_back_done_i |=>
    halt_timing_level_o) else $error("halt missing after write-back");
  a_halt_held: assert property (halt_timing_level_o && !resume_timing_pulse_o |=>
    halt_timing_level_o) else $error("halt dropped early");
  a_resume_pulse: assert property ($rose(resume_timing_pulse_o) |->
    halt_timing_level_o ##1 (!resume_timing_pulse_o && !halt_timing_level_o))
    else $error("resume pulse wrong");
  a_overflow_end: assert property (step_overflow |=>
    r.state == ST_END ##1 resume_timing_pulse_o) else $error("overflow did not end op");
  a_muldiv_add: assert property (addsub_step_o |-> ##1 shift_step_o)
    else $error("add/subtract not followed by shift");
  a_setup_keeps: assert property (option_fetch && instr_func == FUNC_SETUP |=>
    $stable(step_count) ##1 $stable(step_count)) else $error("setup changed step count");
  a_steps_halted: assert property (shift_step_o || addsub_step_o |->
    halt_timing_level_o) else $error("step while timing runs");

  c_muldiv: cover property (start_arithmetic_pulse_o ##[1:200] resume_timing_pulse_o);
  c_shift: cover property (r.state == ST_SHIFT ##1 r.state == ST_END);
  c_setup: cover property (option_fetch && instr_func == FUNC_SETUP);
  c_norm: cover property (r.state == ST_SHIFT && norm_done_i);
endmodule

// >>> rtl/arith_option_pkg.sv
// shared constants and types for the arithmetic option sequencer
// assumes an 18-bit instruction word whose bit 0 (most significant) sits at bit 17
package arith_option_pkg;

  // ************************************************************
  // instruction word layout
  // ************************************************************
  localparam int WORD_W = 18;
  localparam int OPCODE_W = 4;
  localparam int OPCODE_LSB = 14; // instruction bits 0-3
  localparam int FUNC_W = 3;
  localparam int FUNC_LSB = 6; // instruction bits 9-11
  localparam int COUNT_W = 6;
  localparam int COUNT_LSB = 0; // instruction bits 12-17

  // ************************************************************
  // codes
  // ************************************************************
  localparam logic [OPCODE_W-1:0] OPTION_OPCODE = 4'hd; // arbitrary
  localparam logic [OPCODE_W-1:0] DEPOSIT_ZERO_OPCODE = 4'hc; // octal 14
  localparam logic [FUNC_W-1:0] FUNC_SETUP = 3'h0;
  localparam logic [FUNC_W-1:0] FUNC_MUL = 3'h1;
  localparam logic [FUNC_W-1:0] FUNC_DIV = 3'h3;
  localparam logic [FUNC_W-1:0] FUNC_NORM = 3'h4;
  localparam logic [FUNC_W-1:0] FUNC_LONG_RIGHT = 3'h5;
  localparam logic [FUNC_W-1:0] FUNC_LONG_LEFT = 3'h6;
  localparam logic [FUNC_W-1:0] FUNC_ACC_LEFT = 3'h7;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [COUNT_W-1:0] STEP_COUNT_RESET = 6'h00;
  localparam logic [FUNC_W-1:0] FUNC_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HYBRID, ST_WBACK, ST_ENTRY, ST_MD_ADD, ST_MD_SHIFT, ST_SHIFT, ST_END
  } seq_state_t;

endpackage

// >>> rtl/step_counter.sv
// step counter: counts operation steps up from a loaded start value
// assumes load and step come from logic on the same clock
`timescale 1ns/1ps
module step_counter #(
  parameter int W = 6
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic step_i,
  output logic [W-1:0] count_o,
  output logic last_o,
  output logic overflow_o
);
  import arith_option_pkg::*;

  typedef struct packed {
    logic [W-1:0] count;
  } step_reg_t;

  step_reg_t r;
  step_reg_t next_r;

  // ************************************************************
  // counting
  // ************************************************************
  // load wins over step; the counter wraps to zero on overflow
  always_comb begin
    next_r = r;
    if (load_i) begin
      next_r.count = value_i;
    end else if (step_i) begin
      next_r.count = r.count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r.count <= W'(STEP_COUNT_RESET);
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // overflow is the step that carries out of the top bit
  assign count_o = r.count;
  assign last_o = &r.count;
  assign overflow_o = step_i & (&r.count);
endmodule

// >>> sim/proc_timing_model.sv
// processor timing chain model: fetch cycle, hybrid cycle, halt and restart
// assumes go_i is held until fetch_o is seen high, all on the design clock
`timescale 1ns/1ps
module proc_timing_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic mem_i,
  input wire logic [17:0] word_i,
  input wire logic halt_i,
  output logic t1_o,
  output logic t2_o,
  output logic t3_o,
  output logic fetch_o,
  output logic wb_o,
  output logic [17:0] instr_o
);
  logic [11:0] program_counter = 12'h000;
  logic [11:0] memory_address_register = 12'h000;
  initial begin
    {t1_o, t2_o, t3_o, fetch_o, wb_o} = 5'h00;
    instr_o = 18'h00000;
  end
  // one instruction: fetch, optional hybrid, then wait out the option
  always begin
    @(posedge clk_i);
    if (go_i) begin
      fetch_o <= 1'b1;
      instr_o <= word_i;
      t1_o <= 1'b1;
      memory_address_register <= program_counter;
      program_counter <= program_counter + 12'h001;
      @(posedge clk_i);
      t1_o <= 1'b0;
      t2_o <= 1'b1;
      @(posedge clk_i);
      t2_o <= 1'b0;
      t3_o <= 1'b1;
      @(posedge clk_i);
      t3_o <= 1'b0;
      fetch_o <= 1'b0;
      instr_o <= ~word_i; // word no longer valid
      if (mem_i) begin
        t1_o <= 1'b1;
        memory_address_register <= program_counter;
        program_counter <= program_counter + 12'h001;
        @(posedge clk_i);
        t1_o <= 1'b0;
        t2_o <= 1'b1;
        @(posedge clk_i);
        t2_o <= 1'b0;
        t3_o <= 1'b1;
        @(posedge clk_i);
        t3_o <= 1'b0;
        wb_o <= 1'b1;
        @(posedge clk_i);
        wb_o <= 1'b0;
      end
      // timing chain stays stopped while the halt level is up
      while (!halt_i) @(posedge clk_i);
      while (halt_i) @(posedge clk_i);
    end
  end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the arithmetic option sequencer
// assumes proc_timing_model drives the timing pulses and instruction word
`timescale 1ns/1ps
module testbench;
  import arith_option_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic norm_done = 1'b0;
  logic go = 1'b0;
  logic mem_sel = 1'b0;
  logic [17:0] word = 18'h00000;
  logic t1, t2, t3, fetch, wb, start, instr_load, halt, resume, addsub_step, shift_step, busy;
  logic [17:0] instr;
  logic [3:0] dz;
  logic [2:0] func;
  int miscompares = 0;
  int checks_done = 0;

  always #20 clk = ~clk;

  proc_timing_model i_proc_timing_model (.clk_i(clk), .go_i(go), .mem_i(mem_sel),
    .word_i(word), .halt_i(halt), .t1_o(t1), .t2_o(t2), .t3_o(t3), .fetch_o(fetch),
    .wb_o(wb), .instr_o(instr));
  arith_option_cycle_sequencer i_arith_option_cycle_sequencer (.clk_i(clk),
    .reset_n_i(reset_n), .clk_en_i(clk_en), .t1_i(t1), .t2_i(t2), .t3_i(t3),
    .fetch_cycle_i(fetch), .instr_i(instr), .write_back_done_i(wb), .norm_done_i(norm_done),
    .start_arithmetic_pulse_o(start), .instruction_register_load_o(instr_load),
    .deposit_zero_opcode_o(dz),
    .halt_timing_level_o(halt), .resume_timing_pulse_o(resume), .addsub_step_o(addsub_step),
    .shift_step_o(shift_step), .busy_o(busy), .func_o(func));

  // ****************************************
  // shared checking
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one option instruction, watched cycle by cycle until the halt level drops
  task automatic run_op(input logic [2:0] f, input logic [5:0] n, input logic mem,
      input int steps, input int pz);
    int sh, ad, st, rs, hr, fin;
    logic ph, pr, ptrig, pht3, ce;
    {sh, ad, st, rs, hr, fin} = '0;
    {ph, pr, ptrig, pht3} = 4'h0;
    word <= {OPTION_OPCODE, 5'h00, f, n};
    mem_sel <= mem;
    go <= 1'b1;
    for (int c = 0; c < 400 && fin == 0; c++) begin
      ce = clk_en;
      @(posedge clk);
      if (fetch) go <= 1'b0;
      if (pz != 0 && c == 6) clk_en <= 1'b0; // freeze mid-operation
      if (pz != 0 && c == 10) clk_en <= 1'b1;
      #1;
      if (ce) begin
        sh += shift_step;
        ad += addsub_step;
        rs += resume;
        if (start) begin
          st++;
          check("instr_load", 1, instr_load);
          check("force_opcode", 32'hc, dz);
          check("start_cause", 1, pht3);
        end
        if (halt && !ph) begin
          hr++;
          check("halt_cause", 1, ptrig);
          check("busy_level", 1, busy);
        end
        if (!halt && ph) begin
          fin = 1;
          check("resume_before_drop", 1, pr);
        end
      end
      ptrig = mem ? wb : (t3 & fetch);
      pht3 = t3 & ~fetch;
      ph = halt;
      pr = resume;
    end
    check("op_finished", 1, fin);
    check("start_pulses", mem, st);
    check("shift_steps", steps, sh);
    check("addsub_steps", mem ? steps : 0, ad);
    check("resume_pulses", 1, rs);
    check("halt_rises", 1, hr);
    check("func_latch", f, func);
    check("busy_after", 0, busy);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_shifts();
    run_op(FUNC_NORM, 6'h03, 1'b0, 3, 0);
    run_op(FUNC_LONG_RIGHT, 6'h01, 1'b0, 1, 0);
    run_op(FUNC_LONG_LEFT, 6'h3f, 1'b0, 63, 0);
    run_op(FUNC_ACC_LEFT, 6'h00, 1'b0, 64, 0);
  endtask

  task automatic test_muldiv();
    run_op(FUNC_MUL, 6'h05, 1'b1, 5, 0);
    run_op(FUNC_DIV, 6'h02, 1'b1, 2, 0);
  endtask

  task automatic test_setup();
    run_op(FUNC_SETUP, 6'h09, 1'b0, 0, 0);
    run_op(3'h2, 6'h11, 1'b0, 0, 0);
  endtask

  task automatic test_norm_early();
    @(posedge clk);
    norm_done <= 1'b1;
    run_op(FUNC_NORM, 6'h0a, 1'b0, 0, 0);
    @(posedge clk);
    norm_done <= 1'b0;
  endtask

  task automatic test_freeze();
    run_op(FUNC_LONG_LEFT, 6'h04, 1'b0, 4, 1);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    test_shifts();
    test_muldiv();
    test_setup();
    test_norm_early();
    test_freeze();
    conclude();
  end

  // watchdog, well above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule
